// [core/cwb_top.v]
// crop window and horizontal pixel binning with output fifo
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cwb_defs.vh"

// ----------------------------------------------------------------------
// output fifo with registered read stage
// ----------------------------------------------------------------------
module cwb_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clocking
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  // fill side
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  // drain side
  output reg out_valid_out,
  input wire out_ready_in,
  output reg [WIDTH-1:0] out_data_out,
  // fill level
  output wire [AW:0] level_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_r;
  reg [AW:0] rd_ptr_r;
  wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
              (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire empty = (wr_ptr_r == rd_ptr_r);
  wire push = in_valid_in && !full;
  wire pop = !empty && (!out_valid_out || out_ready_in);

  assign in_ready_out = !full;
  assign level_out = wr_ptr_r - rd_ptr_r;

  always @(posedge clk_in) begin
    if (ce_in && push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data_in;
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
      out_valid_out <= 1'b0;
      out_data_out <= {WIDTH{1'b0}};
    end else if (ce_in) begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
        out_data_out <= mem[rd_ptr_r[AW-1:0]];
        out_valid_out <= 1'b1;
      end else if (out_ready_in) begin
        out_valid_out <= 1'b0;
      end
    end
  end
endmodule

// How it works
// - window coordinates count in pixels from the array's top left corner.
// - array column and row counts are read-only; writes leave them alone.
// - factor change recomputes maxima and rescales size and offsets.
// - size defaults to maximum; software sets size before offsets.
// - rising factor divides, dropping remainder; falling multiplies back.
// - factors one to four, independent per direction.
// - each group of adjacent pixels is summed into one output pixel.
// - columns combined here; rows combined by the sensor readout.
// - colour sensor with binning delivers a monochrome image.
// - factor three refused on a colour sensor.
// - frame period depends on window height and row factor only, never width.
// - ccd frame: transfer, flush per outside row, readout per window row.
// - cmos frame: fixed overhead plus one line time per two rows.
module cwb_top (
  // clock, reset, enable
  input wire clk_in,
  input wire reset_n_in,
  input wire ce_in,
  // register port
  input wire [5:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  // pixel stream from sensor readout
  input wire pix_valid_in,
  input wire pix_sof_in,
  input wire pix_sol_in,
  input wire [11:0] pix_data_in,
  output reg pix_ready_out,
  output reg [2:0] row_combine_factor_out,
  output reg mono_out,
  // cropped, binned stream
  output wire crop_valid_out,
  input wire crop_ready_in,
  output wire [15:0] crop_data_out
);
  // --------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------
  reg rst_meta_r;
  reg rst_sync_r;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // --------------------------------------------------------------------
  // settings
  // --------------------------------------------------------------------
  reg [15:0] max_columns_allowed_r;
  reg [15:0] max_rows_allowed_r;
  reg [15:0] width_r;
  reg [15:0] height_r;
  reg [15:0] window_col_start_r;
  reg [15:0] window_row_start_r;
  reg [2:0] column_combine_factor_r;
  reg [2:0] row_combine_factor_r;
  reg reject_r;
  reg [31:0] frame_cycles_r;

  // multiply by the old factor, then divide by the new; remainder lost
  function [15:0] rescale;
    input [15:0] v;
    input [2:0] oldf;
    input [2:0] newf;
    reg [17:0] t;
    begin
      t = v * oldf;
      case (newf)
        3'h2: t = t >> 1;
        3'h3: t = t / 3;
        3'h4: t = t >> 2;
        default: t = t;
      endcase
      rescale = t[15:0];
    end
  endfunction

  wire [15:0] wd = reg_wdata_in[15:0];
  wire [2:0] wf = reg_wdata_in[2:0];
  wire wr_go = ce_in && reg_wr_in;
  wire factor_ok = (reg_wdata_in[31:3] == 29'h0) && (wf != 3'h0) &&
                   (wf <= 3'h4) && !(`CWB_IS_COLOUR && wf == 3'h3);
  wire [16:0] w_end = {1'b0, wd} + {1'b0, window_col_start_r};
  wire [16:0] h_end = {1'b0, wd} + {1'b0, window_row_start_r};
  wire [16:0] cs_end = {1'b0, wd} + {1'b0, width_r};
  wire [16:0] rs_end = {1'b0, wd} + {1'b0, height_r};
  wire width_ok = (wd[1:0] == 2'h0) && (wd != 16'h0) &&
                  (w_end <= {1'b0, max_columns_allowed_r});
  wire height_ok = (wd >= `CWB_MIN_ROWS) &&
                   (h_end <= {1'b0, max_rows_allowed_r});
  wire col_ok = (cs_end <= {1'b0, max_columns_allowed_r});
  wire row_ok = (rs_end <= {1'b0, max_rows_allowed_r});

  reg bad_wr;
  always @* begin
    bad_wr = 1'b0;
    if (wr_go) begin
      case (reg_addr_in)
        `CWB_A_WIDTH: bad_wr = !width_ok;
        `CWB_A_HEIGHT: bad_wr = !height_ok;
        `CWB_A_COL_START: bad_wr = !col_ok;
        `CWB_A_ROW_START: bad_wr = !row_ok;
        `CWB_A_COL_FACTOR: bad_wr = !factor_ok;
        `CWB_A_ROW_FACTOR: bad_wr = !factor_ok;
        default: bad_wr = 1'b0;
      endcase
    end
  end

  always @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      max_columns_allowed_r <= `CWB_ARRAY_COLS;
      max_rows_allowed_r <= `CWB_ARRAY_ROWS;
      width_r <= `CWB_ARRAY_COLS;
      height_r <= `CWB_ARRAY_ROWS;
      window_col_start_r <= 16'h0000;
      window_row_start_r <= 16'h0000;
      column_combine_factor_r <= `CWB_FACTOR_RESET;
      row_combine_factor_r <= `CWB_FACTOR_RESET;
      reject_r <= 1'b0;
    end else if (ce_in) begin
      // a refusal in the clearing cycle keeps the flag set
      if (bad_wr) begin
        reject_r <= 1'b1;
      end else if (wr_go && reg_addr_in == `CWB_A_STATUS &&
                   reg_wdata_in[`CWB_ST_REJECT]) begin
        reject_r <= 1'b0;
      end
      if (wr_go && !bad_wr) begin
        case (reg_addr_in)
          `CWB_A_WIDTH: width_r <= wd;
          `CWB_A_HEIGHT: height_r <= wd;
          `CWB_A_COL_START: window_col_start_r <= wd;
          `CWB_A_ROW_START: window_row_start_r <= wd;
          `CWB_A_COL_FACTOR: begin
            column_combine_factor_r <= wf;
            max_columns_allowed_r <= rescale(`CWB_ARRAY_COLS, 3'h1, wf);
            width_r <= rescale(width_r, column_combine_factor_r, wf);
            window_col_start_r <= rescale(window_col_start_r,
                                          column_combine_factor_r, wf);
          end
          `CWB_A_ROW_FACTOR: begin
            row_combine_factor_r <= wf;
            max_rows_allowed_r <= rescale(`CWB_ARRAY_ROWS, 3'h1, wf);
            height_r <= rescale(height_r, row_combine_factor_r, wf);
            window_row_start_r <= rescale(window_row_start_r,
                                          row_combine_factor_r, wf);
          end
          default: begin
            // read-only and unmapped offsets ignore writes
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // frame period from height and row factor
  // --------------------------------------------------------------------
  wire [31:0] rows_in = height_r * row_combine_factor_r;
  wire [31:0] rows_out = ({16'h0, `CWB_ARRAY_ROWS} > rows_in) ?
                         ({16'h0, `CWB_ARRAY_ROWS} - rows_in) : 32'h0;
  wire [31:0] ccd_cyc = `CWB_VCCD_CYC + `CWB_FLUSH_CYC * rows_out +
                        `CWB_LINE_CYC * {16'h0, height_r};
  wire [31:0] cmos_cyc = `CWB_FOT_CYC +
                         ((`CWB_CMOS_LINE_CYC * {16'h0, height_r}) >> 1);

  always @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      frame_cycles_r <= 32'h0;
      row_combine_factor_out <= `CWB_FACTOR_RESET;
      mono_out <= 1'b0;
    end else if (ce_in) begin
      frame_cycles_r <= `CWB_IS_CMOS ? cmos_cyc : ccd_cyc;
      row_combine_factor_out <= row_combine_factor_r;
      mono_out <= `CWB_IS_COLOUR && (column_combine_factor_r != 3'h1 ||
                  row_combine_factor_r != 3'h1);
    end
  end

  // --------------------------------------------------------------------
  // register read port
  // --------------------------------------------------------------------
  always @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      reg_rdata_out <= 32'h0;
    end else if (ce_in) begin
      reg_rdata_out <= 32'h0;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `CWB_A_ARRAY_COLS: reg_rdata_out <= {16'h0, `CWB_ARRAY_COLS};
          `CWB_A_ARRAY_ROWS: reg_rdata_out <= {16'h0, `CWB_ARRAY_ROWS};
          `CWB_A_MAX_COLS: reg_rdata_out <= {16'h0, max_columns_allowed_r};
          `CWB_A_MAX_ROWS: reg_rdata_out <= {16'h0, max_rows_allowed_r};
          `CWB_A_WIDTH: reg_rdata_out <= {16'h0, width_r};
          `CWB_A_HEIGHT: reg_rdata_out <= {16'h0, height_r};
          `CWB_A_COL_START: reg_rdata_out <= {16'h0, window_col_start_r};
          `CWB_A_ROW_START: reg_rdata_out <= {16'h0, window_row_start_r};
          `CWB_A_COL_FACTOR: reg_rdata_out <= {29'h0, column_combine_factor_r};
          `CWB_A_ROW_FACTOR: reg_rdata_out <= {29'h0, row_combine_factor_r};
          `CWB_A_STATUS: reg_rdata_out <= {29'h0, `CWB_IS_COLOUR, mono_out,
                                           reject_r};
          `CWB_A_FRAME_CYC: reg_rdata_out <= frame_cycles_r;
          default: reg_rdata_out <= 32'h0;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // column combining and cropping
  // --------------------------------------------------------------------
  // counters track binned coordinates of the incoming, row-binned lines
  reg [2:0] phase_r;
  reg [13:0] sum_r;
  reg [15:0] bcol_r;
  reg [15:0] row_r;
  reg first_line_r;
  reg line_first_r;
  reg frame_first_r;
  reg fifo_valid_r;
  reg [15:0] fifo_word_r;
  wire fifo_ready;
  wire [`CWB_FIFO_AW:0] fifo_level;

  wire take = ce_in && pix_valid_in && pix_ready_out;
  wire [2:0] ph = pix_sol_in ? 3'h0 : phase_r;
  wire [15:0] bc = pix_sol_in ? 16'h0 : bcol_r;
  wire [15:0] rw = pix_sof_in ? 16'h0 :
                   (pix_sol_in && !first_line_r) ? row_r + 16'h1 : row_r;
  wire [13:0] acc = ((ph == 3'h0) ? 14'h0 : sum_r) + {2'h0, pix_data_in};
  wire grp_done = (ph + 3'h1 == column_combine_factor_r);
  wire [16:0] c_end = {1'b0, window_col_start_r} + {1'b0, width_r};
  wire [16:0] r_end = {1'b0, window_row_start_r} + {1'b0, height_r};
  wire in_win = (bc >= window_col_start_r) && ({1'b0, bc} < c_end) &&
                (rw >= window_row_start_r) && ({1'b0, rw} < r_end);
  wire new_line = pix_sol_in || (bc != bcol_r) || (rw != row_r);
  wire sof_now = pix_sof_in || frame_first_r;

  always @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      phase_r <= 3'h0;
      sum_r <= 14'h0;
      bcol_r <= 16'h0;
      row_r <= 16'h0;
      first_line_r <= 1'b1;
      line_first_r <= 1'b0;
      frame_first_r <= 1'b0;
      fifo_valid_r <= 1'b0;
      fifo_word_r <= 16'h0;
      pix_ready_out <= 1'b0;
    end else if (ce_in) begin
      // two slots of margin cover the registered ready and fifo_word_r
      pix_ready_out <= (fifo_level < `CWB_FIFO_DEPTH - 2);
      if (fifo_ready) begin
        fifo_valid_r <= 1'b0;
      end
      if (take) begin
        if (pix_sof_in) begin
          first_line_r <= 1'b0;
          frame_first_r <= 1'b1;
        end
        if (pix_sol_in) begin
          line_first_r <= 1'b1;
        end
        row_r <= rw;
        if (grp_done) begin
          phase_r <= 3'h0;
          bcol_r <= bc + 16'h1;
          if (in_win) begin
            fifo_valid_r <= 1'b1;
            fifo_word_r <= {sof_now, line_first_r || pix_sol_in ||
                            (bc == window_col_start_r), acc};
            frame_first_r <= 1'b0;
            line_first_r <= 1'b0;
          end
        end else begin
          phase_r <= ph + 3'h1;
          bcol_r <= bc;
          sum_r <= acc;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // output buffer
  // --------------------------------------------------------------------
  cwb_fifo #(
    .WIDTH(`CWB_WORD_W),
    .DEPTH(`CWB_FIFO_DEPTH),
    .AW(`CWB_FIFO_AW)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_sync_r),
    .ce_in(ce_in),
    .in_valid_in(fifo_valid_r),
    .in_ready_out(fifo_ready),
    .in_data_in(fifo_word_r),
    .out_valid_out(crop_valid_out),
    .out_ready_in(crop_ready_in),
    .out_data_out(crop_data_out),
    .level_out(fifo_level)
  );
endmodule
`default_nettype wire

// [core/cwb_defs.vh]
// constants for the crop window and pixel binning block
`ifndef CWB_DEFS_VH
`define CWB_DEFS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CWB_A_ARRAY_COLS 6'h00
`define CWB_A_ARRAY_ROWS 6'h04
`define CWB_A_MAX_COLS 6'h08
`define CWB_A_MAX_ROWS 6'h0c
`define CWB_A_WIDTH 6'h10
`define CWB_A_HEIGHT 6'h14
`define CWB_A_COL_START 6'h18
`define CWB_A_ROW_START 6'h1c
`define CWB_A_COL_FACTOR 6'h20
`define CWB_A_ROW_FACTOR 6'h24
`define CWB_A_STATUS 6'h28
`define CWB_A_FRAME_CYC 6'h2c

// ----------------------------------------------------------------------
// status fields and sensor model
// ----------------------------------------------------------------------
`define CWB_ST_REJECT 0
`define CWB_ST_MONO 1
`define CWB_ST_COLOUR 2
`define CWB_IS_COLOUR 1'b0
`define CWB_IS_CMOS 1'b0
`define CWB_ARRAY_COLS 16'h0280
`define CWB_ARRAY_ROWS 16'h01e8
`define CWB_MIN_ROWS 16'h003c
`define CWB_FACTOR_RESET 3'h1

// ----------------------------------------------------------------------
// frame timing, times in ns, clock in MHz
// ----------------------------------------------------------------------
`define CWB_CLK_MHZ 40
`define CWB_T_VCCD_NS 25000
`define CWB_T_LINE_NS 16800
`define CWB_T_FLUSH_NS 2600
`define CWB_T_FOT_NS 116700
`define CWB_T_CMOS_LINE_NS 9730
`define CWB_VCCD_CYC ((`CWB_T_VCCD_NS * `CWB_CLK_MHZ) / 1000)
`define CWB_LINE_CYC ((`CWB_T_LINE_NS * `CWB_CLK_MHZ) / 1000)
`define CWB_FLUSH_CYC ((`CWB_T_FLUSH_NS * `CWB_CLK_MHZ) / 1000)
`define CWB_FOT_CYC ((`CWB_T_FOT_NS * `CWB_CLK_MHZ) / 1000)
`define CWB_CMOS_LINE_CYC ((`CWB_T_CMOS_LINE_NS * `CWB_CLK_MHZ) / 1000)

// ----------------------------------------------------------------------
// stream buffer
// ----------------------------------------------------------------------
`define CWB_FIFO_DEPTH 8
`define CWB_FIFO_AW 3
`define CWB_WORD_W 16

`endif

// [testbench/cwb_top_asserts.sv]
// port checker for the crop window and binning block
`timescale 1ns/1ps
`default_nettype none
module cwb_top_asserts (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // register port
  input wire logic [5:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // pixel side
  input wire logic pix_ready_out,
  input wire logic [2:0] row_combine_factor_out,
  input wire logic mono_out,
  // cropped stream
  input wire logic crop_valid_out,
  input wire logic crop_ready_in,
  input wire logic [15:0] crop_data_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  wire rd = reg_rd_in && ce_in;
  wire wr = reg_wr_in && ce_in;
  wire [2:0] fw = reg_wdata_in[2:0];
  wire fwr = wr && reg_addr_in == 6'h24;

  rdata_idle_a: assert property (ce_in && !reg_rd_in |=> reg_rdata_out == 0)
    else $error("read data not zero outside read");
  cols_ro_a: assert property (rd && reg_addr_in == 6'h00 |=> reg_rdata_out == 32'h280)
    else $error("array columns wrong");
  rows_ro_a: assert property (rd && reg_addr_in == 6'h04 |=> reg_rdata_out == 32'h1e8)
    else $error("array rows wrong");
  unmapped_zero_a: assert property (rd && reg_addr_in > 6'h2f |=> reg_rdata_out == 0)
    else $error("unmapped read not zero");
  factor_follow_a: assert property (fwr && fw != 0 && fw <= 4 |-> ##2 row_combine_factor_out == $past(fw, 2))
    else $error("row factor output not updated");
  factor_keep_a: assert property (fwr && (fw == 0 || fw > 4) |=> ##1 $stable(row_combine_factor_out))
    else $error("bad row factor accepted");
  factor_range_a: assert property (row_combine_factor_out != 0 && row_combine_factor_out <= 4)
    else $error("row factor out of range");
  mono_status_a: assert property (rd && reg_addr_in == 6'h28 |=> reg_rdata_out[2:1] == 2'b00 && !mono_out)
    else $error("mono flags set on mono sensor");
  crop_hold_a: assert property (crop_valid_out && !crop_ready_in && ce_in |=> crop_valid_out && $stable(crop_data_out))
    else $error("stalled output changed");
endmodule
`default_nettype wire

// [testbench/cwb_sensor_model.sv]
// sensor readout model feeding pixel lines
`timescale 1ns/1ps
`default_nettype none
module cwb_sensor_model (
  // clock and control
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic gap_in,
  input wire logic [7:0] cols_in,
  input wire logic [7:0] rows_in,
  input wire logic [2:0] row_f_in,
  input wire logic pix_ready_in,
  // pixel stream
  output logic valid_out,
  output logic sof_out,
  output logic sol_out,
  output logic [11:0] data_out,
  output logic done_out
);
  logic rdy_q;
  // ready as the next rising edge will sample it
  always @(negedge clk_in) rdy_q <= pix_ready_in;
  initial begin
    valid_out = 1'b0;
    sof_out = 1'b0;
    sol_out = 1'b0;
    data_out = 12'h000;
    done_out = 1'b0;
    forever begin
      @(posedge clk_in);
      if (start_in) begin
        // rows already combined here, so fewer lines go out
        for (int r = 0; r < rows_in / row_f_in; r++) begin
          for (int c = 0; c < cols_in; c++) begin
            valid_out <= 1'b1;
            sof_out <= (r == 0 && c == 0);
            sol_out <= (c == 0);
            data_out <= 12'(c + 1);
            do @(posedge clk_in); while (!rdy_q);
            if (gap_in) begin
              valid_out <= 1'b0;
              data_out <= ~data_out;
              @(posedge clk_in);
            end
          end
        end
        // idle data differs from the last pixel unless gap_in is set
        valid_out <= 1'b0;
        sof_out <= 1'b0;
        sol_out <= 1'b0;
        data_out <= ~data_out;
        done_out <= 1'b1;
        @(posedge clk_in);
        done_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the crop window and binning block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [5:0] reg_addr_in = 6'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic pix_valid_in, pix_sof_in, pix_sol_in, pix_ready_out, mono_out;
  logic [11:0] pix_data_in;
  logic [2:0] row_combine_factor_out;
  logic crop_valid_out, done;
  logic crop_ready_in = 1'b1;
  logic [15:0] crop_data_out;
  logic start = 1'b0;
  logic gap = 1'b0;
  int err_count = 0;
  int tests_run = 0;
  logic [31:0] rst_v [0:12] = '{32'h280, 32'h1e8, 32'h280, 32'h1e8,
    32'h280, 32'h1e8, 32'h0, 32'h0, 32'h1, 32'h1, 32'h0, 32'h504e8, 32'h0};
  logic [5:0] bad_a [0:3] = '{6'h10, 6'h14, 6'h20, 6'h24};
  logic [31:0] bad_d [0:3] = '{32'h102, 32'h3b, 32'h5, 32'h0};

  always #12.5 clk_in = ~clk_in;

  cwb_top u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(1'b1),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .pix_valid_in(pix_valid_in),
    .pix_sof_in(pix_sof_in), .pix_sol_in(pix_sol_in),
    .pix_data_in(pix_data_in), .pix_ready_out(pix_ready_out),
    .row_combine_factor_out(row_combine_factor_out), .mono_out(mono_out),
    .crop_valid_out(crop_valid_out), .crop_ready_in(crop_ready_in),
    .crop_data_out(crop_data_out));

  cwb_sensor_model u_sensor (.clk_in(clk_in), .start_in(start),
    .gap_in(gap), .cols_in(8'h09), .rows_in(8'h04),
    .row_f_in(row_combine_factor_out), .pix_ready_in(pix_ready_out),
    .valid_out(pix_valid_in), .sof_out(pix_sof_in), .sol_out(pix_sol_in),
    .data_out(pix_data_in), .done_out(done));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task rd(input logic [5:0] a, input logic [31:0] e, input string m);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, e, m);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_reset;
    for (int i = 0; i < 13; i++) rd(6'(i * 4), rst_v[i], "reset value");
    wr(6'h00, 32'h10);
    wr(6'h04, 32'h10);
    for (int i = 0; i < 2; i++) rd(6'(i * 4), rst_v[i], "read-only");
    chk(32'(row_combine_factor_out), 32'h1, "row factor out");
    $display("test reset done");
  endtask
  task t_bad;
    for (int i = 0; i < 4; i++) begin
      wr(bad_a[i], bad_d[i]);
      rd(6'h28, 32'h1, "reject flag");
      wr(6'h28, 32'h1);
    end
    rd(6'h10, 32'h280, "width kept");
    rd(6'h14, 32'h1e8, "height kept");
    rd(6'h20, 32'h1, "factor kept");
    rd(6'h24, 32'h1, "row factor kept");
    rd(6'h28, 32'h0, "flag cleared");
    $display("test bad writes done");
  endtask
  task t_window;
    wr(6'h10, 32'h100);
    wr(6'h18, 32'h180);
    rd(6'h18, 32'h180, "col start at edge");
    wr(6'h18, 32'h184);
    rd(6'h18, 32'h180, "col start past edge");
    rd(6'h28, 32'h1, "overflow flagged");
    wr(6'h28, 32'h1);
    wr(6'h14, 32'h64);
    wr(6'h1c, 32'h184);
    rd(6'h2c, 32'h1a808, "frame cycles");
    wr(6'h10, 32'h40);
    rd(6'h2c, 32'h1a808, "width vs frame");
    $display("test window done");
  endtask
  task t_factor;
    wr(6'h18, 32'h0);
    wr(6'h10, 32'h1f4);
    wr(6'h20, 32'h3);
    rd(6'h10, 32'ha6, "width div 3");
    rd(6'h08, 32'hd5, "max cols div 3");
    wr(6'h20, 32'h1);
    rd(6'h10, 32'h1f2, "width no restore");
    rd(6'h08, 32'h280, "max cols back");
    wr(6'h1c, 32'h0);
    wr(6'h14, 32'hc8);
    wr(6'h24, 32'h2);
    rd(6'h14, 32'h64, "height div 2");
    rd(6'h0c, 32'hf4, "max rows div 2");
    chk(32'(row_combine_factor_out), 32'h2, "row factor out");
    rd(6'h2c, 32'h17f68, "binned frame");
    wr(6'h24, 32'h1);
    rd(6'h14, 32'hc8, "height back");
    wr(6'h20, 32'h4);
    rd(6'h08, 32'ha0, "max cols div 4");
    wr(6'h20, 32'h2);
    rd(6'h10, 32'hf8, "width 4 to 2");
    chk(32'(mono_out), 32'h0, "mono flag");
    $display("test factors done");
  endtask
  // nine pixels a line at factor 2: sums 3,7,11,15, ninth pixel unpaired; window keeps 1..3
  task t_stream(input logic g, input logic stall, input logic [31:0] row0,
                input int nexp);
    int n;
    int k;
    wr(6'h10, 32'h4);
    wr(6'h18, 32'h1);
    wr(6'h1c, row0);
    @(posedge clk_in);
    gap <= g;
    crop_ready_in <= !stall;
    start <= 1'b1;
    @(posedge clk_in);
    start <= 1'b0;
    n = 0;
    k = 0;
    if (stall) begin
      while (pix_ready_out !== 1'b0 && n < 300) begin
        @(negedge clk_in);
        n++;
      end
      chk(32'(pix_ready_out), 32'h0, "refused when full");
      repeat (20) @(posedge clk_in);
      crop_ready_in <= 1'b1;
    end
    n = 0;
    while (n < 600) begin
      @(negedge clk_in);
      n++;
      if (crop_valid_out === 1'b1 && crop_ready_in === 1'b1) begin
        chk(32'(crop_data_out[13:0]), 32'(7 + 4 * (k % 3)), "sum");
        chk(32'(crop_data_out[15:14]), 32'({k == 0, k % 3 == 0}),
            "frame and line flags");
        k++;
      end
    end
    chk(32'(k), 32'(nexp), "pixel count");
    $display("test stream done");
  endtask

  initial begin
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    t_reset;
    t_bad;
    t_window;
    t_factor;
    t_stream(1'b0, 1'b1, 32'h1, 9);
    t_stream(1'b1, 1'b0, 32'h0, 12);
    final_report;
  end
  // about 1500 cycles are expected; far more means a hang
  initial begin
    #300000;
    err_count++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    final_report;
  end
endmodule

bind cwb_top cwb_top_asserts u_chk (.clk_in, .reset_n_in, .ce_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
  .pix_ready_out, .row_combine_factor_out, .mono_out, .crop_valid_out,
  .crop_ready_in, .crop_data_out);
`default_nettype wire
